// ---- hdl/firs_top.sv ----
// Stream port shell of a time-multiplexed FIR filter with framing checks.
`timescale 1ns/1ps
`include "firs_map.svh"

module firs_top
  import firs_pkg::*;
#(
  parameter int          DATA_W    = 16,
  parameter int          COEF_W    = 16,
  parameter int          CFG_W     = 8,
  parameter int          USER_W    = 4,
  parameter int          CHANNELS  = 4,
  parameter int          TAPS      = `FIRS_RELOAD_WORDS,
  parameter int          CFG_WORDS = `FIRS_CFG_WORDS,
  parameter int          LATENCY   = `FIRS_LATENCY,
  parameter firs_frame_t FRAMING   = FIRS_FRAME_VECTOR
) (
  // Clock, enable and clear
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      clk_en_i,
  input  wire logic                      clear_n_i,
  // Cycles per sample, zero and one both mean every cycle
  input  wire logic [7:0]                cycles_per_sample_i,
  // Configuration channel
  input  wire logic                      s_axis_config_tvalid,
  output logic                           s_axis_config_tready,
  input  wire logic [CFG_W-1:0]          s_axis_config_tdata,
  input  wire logic                      s_axis_config_tlast,
  // Coefficient reload channel
  input  wire logic                      s_axis_reload_tvalid,
  output logic                           s_axis_reload_tready,
  input  wire logic [COEF_W-1:0]         s_axis_reload_tdata,
  input  wire logic                      s_axis_reload_tlast,
  // Sample input channel
  input  wire logic                      s_axis_data_tvalid,
  output logic                           s_axis_data_tready,
  input  wire logic [DATA_W-1:0]         s_axis_data_tdata,
  input  wire logic [USER_W+((CHANNELS > 1) ? $clog2(CHANNELS) : 1)-1:0] s_axis_data_tuser,
  input  wire logic                      s_axis_data_tlast,
  // Result output channel
  output logic                           m_axis_data_tvalid,
  input  wire logic                      m_axis_data_tready,
  output logic [DATA_W+COEF_W-1:0]       m_axis_data_tdata,
  output logic [USER_W+((CHANNELS > 1) ? $clog2(CHANNELS) : 1):0] m_axis_data_tuser,
  output logic                           m_axis_data_tlast,
  // Event pulses
  output logic                           event_s_data_tlast_missing,
  output logic                           event_s_data_tlast_unexpected,
  output logic                           event_s_data_channel_tag_incorrect,
  output logic                           event_s_reload_tlast_missing,
  output logic                           event_s_reload_tlast_unexpected,
  output logic                           event_s_config_tlast_missing,
  output logic                           event_s_config_tlast_unexpected
);

  localparam int TW = (CHANNELS > 1) ? $clog2(CHANNELS) : 1;
  localparam int OW = DATA_W + COEF_W;
  localparam int UW = USER_W + TW;

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  // Clear and enable come from pins; a level counts once stages two and three agree.
  logic [`FIRS_SYNC_STAGES-1:0] clr_sync_ff;
  logic [`FIRS_SYNC_STAGES-1:0] en_sync_ff;
  logic                         clr_q_ff;
  logic                         en_q_ff;
  logic                         nxt_clr_q;
  logic                         nxt_en_q;
  logic                         clr;
  logic                         run;

  always_comb begin
    nxt_clr_q = clr_q_ff;
    nxt_en_q  = en_q_ff;
    if (clr_sync_ff[1] == clr_sync_ff[2]) begin
      nxt_clr_q = clr_sync_ff[2];
    end
    if (en_sync_ff[1] == en_sync_ff[2]) begin
      nxt_en_q = en_sync_ff[2];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      clr_sync_ff <= '0;
      en_sync_ff  <= '0;
      clr_q_ff    <= 1'b0;
      en_q_ff     <= 1'b0;
    end else begin
      clr_sync_ff <= {clr_sync_ff[`FIRS_SYNC_STAGES-2:0], !clear_n_i};
      en_sync_ff  <= {en_sync_ff[`FIRS_SYNC_STAGES-2:0], clk_en_i};
      clr_q_ff    <= nxt_clr_q;
      en_q_ff     <= nxt_en_q;
    end
  end

  // A held clear of two cycles survives the synchroniser; shorter pulses may be lost.
  assign clr = clr_q_ff;
  assign run = en_q_ff && !clr;

  // ---------------------------------------------------------------------------
  // Coefficients and configuration
  // ---------------------------------------------------------------------------
  localparam int CI = (TAPS > 1) ? $clog2(TAPS) : 1;

  logic [COEF_W-1:0] coef_ff [TAPS];
  logic [COEF_W-1:0] nxt_coef [TAPS];
  logic [CI-1:0]     coef_idx_ff;
  logic [CI-1:0]     nxt_coef_idx;
  logic [CFG_W-1:0]  cfg_ff;
  logic [CFG_W-1:0]  nxt_cfg;
  logic              cfg_rdy_ff;
  logic              rld_rdy_ff;
  logic              nxt_cfg_rdy;
  logic              nxt_rld_rdy;
  logic              cfg_xfer;
  logic              rld_xfer;

  assign cfg_xfer = run && s_axis_config_tvalid && cfg_rdy_ff;
  assign rld_xfer = run && s_axis_reload_tvalid && rld_rdy_ff;

  always_comb begin
    nxt_coef     = coef_ff;
    nxt_coef_idx = coef_idx_ff;
    nxt_cfg      = cfg_ff;
    nxt_cfg_rdy  = cfg_rdy_ff;
    nxt_rld_rdy  = rld_rdy_ff;
    if (clr) begin
      nxt_coef_idx = '0;
      nxt_cfg_rdy  = 1'b0;
      nxt_rld_rdy  = 1'b0;
    end else if (run) begin
      // Both side channels are always able to take a word while the block runs.
      nxt_cfg_rdy = 1'b1;
      nxt_rld_rdy = 1'b1;
      if (cfg_xfer) begin
        nxt_cfg = s_axis_config_tdata;
      end
      if (rld_xfer) begin
        nxt_coef[coef_idx_ff] = s_axis_reload_tdata;
        nxt_coef_idx = (s_axis_reload_tlast || coef_idx_ff == CI'(TAPS - 1)) ? '0 : coef_idx_ff + CI'(1);
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      coef_ff     <= '{default: '0};
      coef_idx_ff <= '0;
      cfg_ff      <= '0;
      cfg_rdy_ff  <= 1'b0;
      rld_rdy_ff  <= 1'b0;
    end else begin
      coef_ff     <= nxt_coef;
      coef_idx_ff <= nxt_coef_idx;
      cfg_ff      <= nxt_cfg;
      cfg_rdy_ff  <= nxt_cfg_rdy;
      rld_rdy_ff  <= nxt_rld_rdy;
    end
  end

  // ---------------------------------------------------------------------------
  // Sample intake and channel counter
  // ---------------------------------------------------------------------------
  logic [7:0]    pace_ff;
  logic [7:0]    nxt_pace;
  logic [TW-1:0] chan_ff;
  logic [TW-1:0] nxt_chan;
  logic          in_rdy_ff;
  logic          nxt_in_rdy;
  logic          stall;
  logic          in_xfer;
  logic          chan_last;
  logic          ev_dmiss_ff;
  logic          ev_dunex_ff;
  logic          ev_tag_ff;
  logic          nxt_dmiss;
  logic          nxt_dunex;
  logic          nxt_tag;

  // The pipe holds while a result waits, so back-pressure reaches the intake.
  assign stall     = m_axis_data_tvalid && !m_axis_data_tready;
  assign in_xfer   = run && s_axis_data_tvalid && in_rdy_ff && !stall;
  assign chan_last = (chan_ff == TW'(CHANNELS - 1));

  always_comb begin
    nxt_pace   = pace_ff;
    nxt_chan   = chan_ff;
    nxt_in_rdy = in_rdy_ff;
    nxt_dmiss  = ev_dmiss_ff;
    nxt_dunex  = ev_dunex_ff;
    nxt_tag    = ev_tag_ff;
    if (clr) begin
      nxt_pace   = '0;
      nxt_chan   = '0;
      nxt_in_rdy = 1'b0;
      nxt_dmiss  = 1'b0;
      nxt_dunex  = 1'b0;
      nxt_tag    = 1'b0;
    end else if (run) begin
      nxt_dmiss = in_xfer && FRAMING == FIRS_FRAME_VECTOR && chan_last && !s_axis_data_tlast;
      nxt_dunex = in_xfer && FRAMING == FIRS_FRAME_VECTOR && !chan_last && s_axis_data_tlast;
      nxt_tag   = in_xfer && (s_axis_data_tuser[TW-1:0] != chan_ff);
      if (in_xfer) begin
        nxt_chan   = chan_last ? '0 : chan_ff + TW'(1);
        nxt_pace   = (cycles_per_sample_i > 8'h01) ? cycles_per_sample_i - 8'h01 : 8'h00;
        nxt_in_rdy = (cycles_per_sample_i <= 8'h01);
      end else if (pace_ff != 8'h00) begin
        nxt_pace   = pace_ff - 8'h01;
        nxt_in_rdy = (pace_ff == 8'h01);
      end else begin
        nxt_in_rdy = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pace_ff     <= '0;
      chan_ff     <= '0;
      in_rdy_ff   <= 1'b0;
      ev_dmiss_ff <= 1'b0;
      ev_dunex_ff <= 1'b0;
      ev_tag_ff   <= 1'b0;
    end else begin
      pace_ff     <= nxt_pace;
      chan_ff     <= nxt_chan;
      in_rdy_ff   <= nxt_in_rdy;
      ev_dmiss_ff <= nxt_dmiss;
      ev_dunex_ff <= nxt_dunex;
      ev_tag_ff   <= nxt_tag;
    end
  end

  // ---------------------------------------------------------------------------
  // Fixed-latency result pipe
  // ---------------------------------------------------------------------------
  // Arithmetic is a product with the first tap; the pipe length is what matters here.
  logic          pv_ff   [LATENCY];
  logic [OW-1:0] pd_ff   [LATENCY];
  logic [UW-1:0] pu_ff   [LATENCY];
  logic          pl_ff   [LATENCY];
  logic          nxt_pv  [LATENCY];
  logic [OW-1:0] nxt_pd  [LATENCY];
  logic [UW-1:0] nxt_pu  [LATENCY];
  logic          nxt_pl  [LATENCY];
  logic          dvalid_ff;
  logic          nxt_dvalid;

  always_comb begin
    nxt_pv     = pv_ff;
    nxt_pd     = pd_ff;
    nxt_pu     = pu_ff;
    nxt_pl     = pl_ff;
    nxt_dvalid = dvalid_ff;
    if (clr) begin
      nxt_pv     = '{default: 1'b0};
      nxt_dvalid = `FIRS_DVALID_RST;
    end else if (run && !stall) begin
      // One shift per advance keeps latency fixed in advancing cycles.
      nxt_pv[0] = in_xfer;
      nxt_pd[0] = OW'($signed(s_axis_data_tdata) * $signed(coef_ff[0]));
      nxt_pu[0] = {s_axis_data_tuser[UW-1:TW], chan_ff};
      nxt_pl[0] = (FRAMING == FIRS_FRAME_PACKET) ? s_axis_data_tlast : chan_last;
      for (int i = 1; i < LATENCY; i++) begin
        nxt_pv[i] = pv_ff[i-1];
        nxt_pd[i] = pd_ff[i-1];
        nxt_pu[i] = pu_ff[i-1];
        nxt_pl[i] = pl_ff[i-1];
      end
      if (pv_ff[LATENCY-1]) begin
        nxt_dvalid = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pv_ff     <= '{default: 1'b0};
      pd_ff     <= '{default: '0};
      pu_ff     <= '{default: '0};
      pl_ff     <= '{default: 1'b0};
      dvalid_ff <= `FIRS_DVALID_RST;
    end else begin
      pv_ff     <= nxt_pv;
      pd_ff     <= nxt_pd;
      pu_ff     <= nxt_pu;
      pl_ff     <= nxt_pl;
      dvalid_ff <= nxt_dvalid;
    end
  end

  assign m_axis_data_tvalid = pv_ff[LATENCY-1];
  assign m_axis_data_tdata  = pd_ff[LATENCY-1];
  assign m_axis_data_tuser  = {pu_ff[LATENCY-1], dvalid_ff};
  assign m_axis_data_tlast  = pl_ff[LATENCY-1] && (FRAMING != FIRS_FRAME_NONE);

  assign s_axis_data_tready            = in_rdy_ff;
  assign s_axis_config_tready          = cfg_rdy_ff;
  assign s_axis_reload_tready          = rld_rdy_ff;
  assign event_s_data_tlast_missing    = ev_dmiss_ff;
  assign event_s_data_tlast_unexpected = ev_dunex_ff;
  assign event_s_data_channel_tag_incorrect = ev_tag_ff;

  // ---------------------------------------------------------------------------
  // Side channel packet checks
  // ---------------------------------------------------------------------------
  firs_pkt_check #(.WORDS(TAPS)) u_reload_chk (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .run_i        (run),
    .clr_i        (clr),
    .xfer_i       (rld_xfer),
    .last_i       (s_axis_reload_tlast),
    .missing_o    (event_s_reload_tlast_missing),
    .unexpected_o (event_s_reload_tlast_unexpected)
  );

  firs_pkt_check #(.WORDS(CFG_WORDS)) u_config_chk (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .run_i        (run),
    .clr_i        (clr),
    .xfer_i       (cfg_xfer),
    .last_i       (s_axis_config_tlast),
    .missing_o    (event_s_config_tlast_missing),
    .unexpected_o (event_s_config_tlast_unexpected)
  );

endmodule

// ---- hdl/firs_map.svh ----
// Constant map for the FIR stream port block.
`ifndef FIRS_MAP_SVH
`define FIRS_MAP_SVH

// Number of synchroniser stages on the clear and enable pins.
`define FIRS_SYNC_STAGES    3
// Minimum number of clock cycles the clear must be held low.
`define FIRS_CLEAR_MIN_CYC  2
// Number of transfers in one configuration packet.
`define FIRS_CFG_WORDS      1
// Number of coefficient words in one reload packet.
`define FIRS_RELOAD_WORDS   8
// Pipeline depth from a taken sample to its result.
`define FIRS_LATENCY        4
// Reset value of the data-valid sideband bit.
`define FIRS_DVALID_RST     1'b0
// Bit position of the data-valid flag in the output user field.
`define FIRS_DVALID_POS     0

`endif

// ---- hdl/firs_pkg.sv ----
// Type package for the FIR stream port block.
package firs_pkg;

  typedef enum logic [1:0] {
    FIRS_FRAME_NONE,
    FIRS_FRAME_VECTOR,
    FIRS_FRAME_PACKET
  } firs_frame_t;

endpackage

// ---- hdl/firs_pkt_check.sv ----
// Transfer counter that checks tlast placement on one stream.
`timescale 1ns/1ps

module firs_pkt_check
  import firs_pkg::*;
#(
  parameter int WORDS = 8
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Qualifiers
  input  wire logic run_i,
  input  wire logic clr_i,
  // Observed transfer
  input  wire logic xfer_i,
  input  wire logic last_i,
  // Event pulses
  output logic      missing_o,
  output logic      unexpected_o
);

  localparam int CW = (WORDS > 1) ? $clog2(WORDS) : 1;

  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic          miss_ff;
  logic          nxt_miss;
  logic          unex_ff;
  logic          nxt_unex;
  logic          at_end;

  assign at_end       = (cnt_ff == CW'(WORDS - 1));
  assign missing_o    = miss_ff;
  assign unexpected_o = unex_ff;

  // A word count always restarts on tlast so one bad packet does not skew the next.
  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_miss = miss_ff;
    nxt_unex = unex_ff;
    if (clr_i) begin
      nxt_cnt  = '0;
      nxt_miss = 1'b0;
      nxt_unex = 1'b0;
    end else if (run_i) begin
      nxt_miss = xfer_i && at_end && !last_i;
      nxt_unex = xfer_i && !at_end && last_i;
      if (xfer_i) begin
        nxt_cnt = (at_end || last_i) ? '0 : cnt_ff + CW'(1);
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_ff  <= '0;
      miss_ff <= 1'b0;
      unex_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      miss_ff <= nxt_miss;
      unex_ff <= nxt_unex;
    end
  end

endmodule

// ---- test/firs_checker.sv ----
// Concurrent checks on the FIR stream port block, bound to its top module.
`timescale 1ns/1ps
module firs_checker
  import firs_pkg::*;
#(
  parameter int DATA_W   = 16,
  parameter int COEF_W   = 16,
  parameter int USER_W   = 4,
  parameter int CHANNELS = 4,
  parameter int LATENCY  = 4,
  parameter int TW       = (CHANNELS > 1) ? $clog2(CHANNELS) : 1
) (
  // Clock, enable and clear
  input wire logic                     clk_i,
  input wire logic                     rst_i,
  input wire logic                     clk_en_i,
  input wire logic                     clear_n_i,
  // Input streams
  input wire logic                     s_axis_data_tvalid,
  input wire logic                     s_axis_data_tready,
  input wire logic [USER_W+TW-1:0]     s_axis_data_tuser,
  input wire logic                     s_axis_data_tlast,
  input wire logic                     s_axis_config_tvalid,
  input wire logic                     s_axis_config_tready,
  input wire logic                     s_axis_config_tlast,
  input wire logic                     s_axis_reload_tready,
  // Result stream
  input wire logic                     m_axis_data_tvalid,
  input wire logic                     m_axis_data_tready,
  input wire logic [DATA_W+COEF_W-1:0] m_axis_data_tdata,
  input wire logic [USER_W+TW:0]       m_axis_data_tuser,
  input wire logic                     m_axis_data_tlast,
  // Events
  input wire logic                     event_s_data_tlast_missing,
  input wire logic                     event_s_data_tlast_unexpected,
  input wire logic                     event_s_data_channel_tag_incorrect,
  input wire logic                     event_s_config_tlast_missing,
  input wire logic                     event_s_config_tlast_unexpected
);
  // ----------------------------------------
  // Pin history
  // ----------------------------------------
  // Enable and clear pass a synchroniser, so checks wait until a pin has settled for seven cycles.
  logic [2:0] en_hi_ff, en_lo_ff, cl_hi_ff, cl_lo_ff;
  logic [2:0] nxt_en_hi, nxt_en_lo, nxt_cl_hi, nxt_cl_lo;
  logic       ok, take, cfg_take;

  function automatic logic [2:0] sat(input logic c, input logic [2:0] v);
    return c ? v + {2'h0, v != 3'h7} : 3'h0;
  endfunction

  always_comb begin
    nxt_en_hi = sat(clk_en_i, en_hi_ff);
    nxt_en_lo = sat(!clk_en_i, en_lo_ff);
    nxt_cl_hi = sat(clear_n_i, cl_hi_ff);
    nxt_cl_lo = sat(!clear_n_i, cl_lo_ff);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      en_hi_ff <= 3'h0;
      en_lo_ff <= 3'h0;
      cl_hi_ff <= 3'h0;
      cl_lo_ff <= 3'h0;
    end else begin
      en_hi_ff <= nxt_en_hi;
      en_lo_ff <= nxt_en_lo;
      cl_hi_ff <= nxt_cl_hi;
      cl_lo_ff <= nxt_cl_lo;
    end
  end

  assign ok       = (en_hi_ff == 3'h7) && (cl_hi_ff == 3'h7);
  assign take     = s_axis_data_tvalid && s_axis_data_tready && !(m_axis_data_tvalid && !m_axis_data_tready);
  assign cfg_take = s_axis_config_tvalid && s_axis_config_tready;

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_take;
    take && ok;
  endsequence
  // Three further advancing cycles make the four-cycle pipe of the default build.
  sequence s_flow;
    (m_axis_data_tready && ok) [*3];
  endsequence

  chk_user_latency:
    assert property (s_take ##1 s_flow |=> m_axis_data_tvalid &&
      m_axis_data_tuser[USER_W+TW:TW+1] == $past(s_axis_data_tuser[USER_W+TW-1:TW], LATENCY))
    else $error("user field not aligned with its result");
  chk_stall_hold:
    assert property (m_axis_data_tvalid && !m_axis_data_tready && ok |=> m_axis_data_tvalid &&
      $stable(m_axis_data_tdata) && $stable(m_axis_data_tuser) && $stable(m_axis_data_tlast))
    else $error("result changed while stalled");
  chk_tag_last:
    assert property (m_axis_data_tvalid |-> m_axis_data_tlast == (m_axis_data_tuser[TW:1] == TW'(CHANNELS - 1)))
    else $error("output tlast not on final channel");
  chk_clear_ready:
    assert property (cl_lo_ff == 3'h7 |-> !s_axis_data_tready && !s_axis_config_tready &&
      !s_axis_reload_tready && !m_axis_data_tvalid)
    else $error("ready or valid high during clear");
  chk_disabled_hold:
    assert property (en_lo_ff == 3'h7 && cl_hi_ff == 3'h7 |=> $stable(m_axis_data_tvalid) &&
      $stable(m_axis_data_tdata) && $stable(s_axis_data_tready) && $stable(s_axis_config_tready))
    else $error("outputs moved while disabled");
  chk_data_unexp:
    assert property (event_s_data_tlast_unexpected |-> $past(take && s_axis_data_tlast))
    else $error("unexpected tlast event without cause");
  chk_data_miss:
    assert property (event_s_data_tlast_missing |-> $past(take && !s_axis_data_tlast))
    else $error("missing tlast event without cause");
  chk_tag_cause:
    assert property (event_s_data_channel_tag_incorrect |-> $past(take))
    else $error("channel tag event without sample");
  chk_cfg_event:
    assert property (cfg_take && ok |=> event_s_config_tlast_missing == !$past(s_axis_config_tlast) &&
      !event_s_config_tlast_unexpected)
    else $error("config tlast event wrong");
endmodule

bind firs_top firs_checker #(
  .DATA_W(DATA_W),
  .COEF_W(COEF_W),
  .USER_W(USER_W),
  .CHANNELS(CHANNELS),
  .LATENCY(LATENCY)
) u_firs_checker (.*);

// ---- test/firs_sink.sv ----
// Downstream result sink that can stall the filter output.
`timescale 1ns/1ps
module firs_sink (
  // Clock and control
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        slow_i,
  // Result stream
  input  wire logic        valid_i,
  input  wire logic [31:0] data_i,
  input  wire logic [6:0]  user_i,
  input  wire logic        last_i,
  output logic             ready_o,
  // Result count and last result taken
  output logic [31:0]      count_o,
  output logic [31:0]      data_o,
  output logic [6:0]       user_o,
  output logic             last_o
);
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ready_o <= 1'b0;
      count_o <= 32'h0;
    end else begin
      ready_o <= slow_i ? !ready_o : 1'b1;
      if (valid_i && ready_o) begin
        count_o <= count_o + 32'h1;
        data_o  <= data_i;
        user_o  <= user_i;
        last_o  <= last_i;
      end
    end
  end
endmodule

// ---- test/tb_firs_top.sv ----
// Self-checking bench for the FIR stream port block.
`timescale 1ns/1ps
module tb_firs_top;
  import firs_pkg::*;
  logic        clk_i, rst_i, en, cln, slow, dv, dl, rv, rl, cv, cl, sr, rr, cr, mv, mr, ml, gl;
  logic [7:0]  cps, cd;
  logic [15:0] dd, rd;
  logic [5:0]  du;
  logic [31:0] md, cnt, gd;
  logic [6:0]  mu, gu, ev;
  int          bad_count, checks_done, cyc, gap, ec[7];

  firs_top u_firs_top (.clk_i(clk_i), .rst_i(rst_i), .clk_en_i(en), .clear_n_i(cln), .cycles_per_sample_i(cps),
    .s_axis_config_tvalid(cv), .s_axis_config_tready(cr), .s_axis_config_tdata(cd), .s_axis_config_tlast(cl),
    .s_axis_reload_tvalid(rv), .s_axis_reload_tready(rr), .s_axis_reload_tdata(rd), .s_axis_reload_tlast(rl),
    .s_axis_data_tvalid(dv), .s_axis_data_tready(sr), .s_axis_data_tdata(dd), .s_axis_data_tuser(du),
    .s_axis_data_tlast(dl), .m_axis_data_tvalid(mv), .m_axis_data_tready(mr), .m_axis_data_tdata(md),
    .m_axis_data_tuser(mu), .m_axis_data_tlast(ml), .event_s_data_tlast_missing(ev[0]),
    .event_s_data_tlast_unexpected(ev[1]), .event_s_data_channel_tag_incorrect(ev[2]),
    .event_s_reload_tlast_missing(ev[3]), .event_s_reload_tlast_unexpected(ev[4]),
    .event_s_config_tlast_missing(ev[5]), .event_s_config_tlast_unexpected(ev[6]));
  firs_sink u_firs_sink (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .valid_i(mv), .data_i(md), .user_i(mu),
    .last_i(ml), .ready_o(mr), .count_o(cnt), .data_o(gd), .user_o(gu), .last_o(gl));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // Event pulses are tallied here so that scenarios compare totals.
  always @(posedge clk_i) begin
    cyc++;
    for (int k = 0; k < 7; k++) if (ev[k] === 1'b1) ec[k]++;
    if (cyc == 5000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  function logic acc(input int c);
    return c == 0 ? dv && sr && !(mv && !mr) : (c == 1 ? rv && rr : cv && cr);
  endfunction

  // Offers one transfer just after an edge and returns at the edge that takes it.
  task xfer(input int c, input logic [15:0] d, input logic [5:0] u, input logic l);
    if (c == 0) begin
      dv <= 1'b1;
      dd <= d;
      du <= u;
      dl <= l;
    end else if (c == 1) begin
      rv <= 1'b1;
      rd <= d;
      rl <= l;
    end else begin
      cv <= 1'b1;
      cd <= d[7:0];
      cl <= l;
    end
    gap = 0;
    do begin
      @(posedge clk_i);
      gap++;
    end while (!acc(c));
  endtask

  task idle();
    dv <= 1'b0;
    rv <= 1'b0;
    cv <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask

  task wait_cnt(input logic [31:0] n);
    for (int t = 0; t < 200 && cnt !== n; t++) @(posedge clk_i);
    chk("result count", n, cnt);
  endtask

  task t_reload();
    for (int i = 0; i < 8; i++) xfer(1, 16'h0003, 6'h00, i == 7);
    for (int i = 0; i < 3; i++) xfer(1, 16'h0003, 6'h00, i == 2);
    for (int i = 0; i < 8; i++) xfer(1, 16'h0003, 6'h00, 1'b0);
    idle();
    chk("reload missing", 1, ec[3]);
    chk("reload unexpected", 1, ec[4]);
    $display("test reload done");
  endtask

  task t_cfg();
    xfer(2, 16'h0000, 6'h00, 1'b1);
    xfer(2, 16'h0000, 6'h00, 1'b0);
    idle();
    chk("config missing", 1, ec[5]);
    chk("config unexpected", 0, ec[6]);
    $display("test config done");
  endtask

  task t_stream();
    for (int i = 0; i < 8; i++) xfer(0, i == 7 ? 16'hfffe : 16'(i + 1), {4'(i), 2'(i)}, i % 4 == 3);
    chk("full rate gap", 1, gap);
    idle();
    wait_cnt(8);
    chk("result data", 32'hfffffffa, gd);
    chk("result user", 32'h1f, {26'h0, gu[6:1]});
    chk("result last", 1, gl);
    chk("result valid flag", 1, {31'h0, gu[0]});
    slow <= 1'b1;
    for (int i = 0; i < 4; i++) xfer(0, 16'h0002, {4'h9, 2'(i)}, i == 3);
    idle();
    wait_cnt(12);
    chk("stalled data", 32'h6, gd);
    chk("stalled user", 32'h27, {26'h0, gu[6:1]});
    chk("clean events", 0, ec[0] + ec[1] + ec[2]);
    slow <= 1'b0;
    $display("test stream done");
  endtask

  task t_faults();
    xfer(0, 16'h0001, 6'h00, 1'b1);
    xfer(0, 16'h0001, 6'h03, 1'b0);
    xfer(0, 16'h0001, 6'h02, 1'b0);
    xfer(0, 16'h0001, 6'h03, 1'b0);
    idle();
    chk("data unexpected", 1, ec[1]);
    chk("tag incorrect", 1, ec[2]);
    chk("data missing", 1, ec[0]);
    wait_cnt(16);
    chk("counter tlast", 1, gl);
    $display("test faults done");
  endtask

  task t_pace();
    cps <= 8'h03;
    @(posedge clk_i);
    for (int i = 0; i < 4; i++) xfer(0, 16'h0001, {4'h0, 2'(i)}, i == 3);
    chk("paced gap", 3, gap);
    cps <= 8'h01;
    idle();
    wait_cnt(20);
    $display("test pace done");
  endtask

  task t_clear();
    en <= 1'b0;
    repeat (8) @(posedge clk_i);
    cln <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk("cleared readies", 0, {29'h0, sr, rr, cr});
    cln <= 1'b1;
    repeat (4) @(posedge clk_i);
    en <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk("readies after clear", 7, {29'h0, sr, rr, cr});
    for (int i = 0; i < 4; i++) xfer(0, 16'h0005, {4'h0, 2'(i)}, i == 3);
    idle();
    wait_cnt(24);
    chk("coefficient kept", 32'hf, gd);
    $display("test clear done");
  endtask

  task tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    {rst_i, cln, cps} = {1'b1, 1'b1, 8'h01};
    {en, slow, dv, dl, rv, rl, cv, cl, dd, rd, du, cd} = '0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    en <= 1'b1;
    repeat (8) @(posedge clk_i);
    t_reload();
    t_cfg();
    t_stream();
    t_faults();
    t_pace();
    t_clear();
    tally_and_finish();
  end
endmodule
